// file: common/mte_pkg.sv
/*
 memory transfer engine package: register map, field positions, reset
 values, configuration and bus access carriers, engine states.
 assumes a 32-bit apb slave port and a byte-wide shared data bus.
*/
package mte_pkg;

   localparam int MTE_CH   = 4;
   localparam int MTE_CH_W = 2;

   // global registers
   localparam logic [7:0] MTE_OFF_CTRL  = 8'h00;
   localparam logic [7:0] MTE_OFF_ISTAT = 8'h04;
   localparam logic [7:0] MTE_OFF_IMASK = 8'h08;
   localparam logic [7:0] MTE_OFF_STAT  = 8'h0c;
   // channel c occupies MTE_CH_BASE + c * 0x20
   localparam logic [7:0] MTE_CH_BASE   = 8'h20;
   localparam logic [4:0] MTE_CR_CFG    = 5'h00;
   localparam logic [4:0] MTE_CR_SRC    = 5'h04;
   localparam logic [4:0] MTE_CR_DST    = 5'h08;
   localparam logic [4:0] MTE_CR_LEN    = 5'h0c;
   localparam logic [4:0] MTE_CR_REP    = 5'h10;
   localparam logic [4:0] MTE_CR_LEFT   = 5'h14;

   localparam int MTE_CTRL_EN    = 0;
   localparam int MTE_CTRL_PRIO  = 1;
   localparam int MTE_CFG_W      = 13;
   localparam int MTE_CFG_SWREQ  = 13;
   localparam int MTE_STAT_PEND  = 4;
   localparam int MTE_STAT_BUSY  = 8;
   localparam int MTE_STAT_ACT   = 9;

   // slot 0 highest: channel 0, then 1, 2, 3
   localparam logic [7:0]  MTE_PRIO_RST  = 8'he4;
   localparam logic [7:0]  MTE_IMASK_RST = 8'h00;

   // nonvolatile data window, writes refused
   localparam logic [23:0] MTE_NV_FIRST  = 24'h001000;
   localparam logic [23:0] MTE_NV_LAST   = 24'h001fff;

   // trigger select codes
   localparam logic [3:0] MTE_TRIG_PER0 = 4'h1;
   localparam logic [3:0] MTE_TRIG_PERN = 4'h4;
   localparam logic [3:0] MTE_TRIG_EVT0 = 4'h8;

   localparam logic [1:0] MTE_STEP_INC = 2'b01;
   localparam logic [1:0] MTE_STEP_DEC = 2'b10;

   typedef struct packed {
      logic [3:0] trigSel;
      logic       link;
      logic       reload;
      logic [1:0] dstMode;
      logic [1:0] srcMode;
      logic [1:0] burst;
      logic       en;
   } mte_cfg_t;

   typedef struct packed {
      logic [23:0] addr;
      logic        wr;
      logic [7:0]  wdata;
   } mte_acc_t;

   typedef enum logic [1:0] {
      MTE_ST_IDLE  = 2'b00,
      MTE_ST_READ  = 2'b01,
      MTE_ST_WRITE = 2'b11
   } mte_state_t;

endpackage

// file: hdl/mte_engine.sv
/*
 four-channel memory transfer engine with apb register slave, trigger
 capture, byte mover on the shared data bus and a sticky interrupt.
 assumes an outside bus arbiter that grants the shared bus and a bus
 that acknowledges each access with a one-cycle accAck.
*/
module mte_engine #(
   parameter int PERIPH_W = 4,
   parameter int EVT_W    = 8
) (
   input  wire logic                                       core_clk,
   input  wire logic                                       sys_rst,
   input  wire logic                                       psel,
   input  wire logic                                       penable,
   input  wire logic                                       pwrite,
   input  wire logic [7:0]                                 paddr,
   input  wire logic [31:0]                                pwdata,
   output logic [31:0]                                     prdata,
   output logic                                            pready,
   output logic                                            pslverr,
   input  wire logic [mte_pkg::MTE_CH-1:0][PERIPH_W-1:0]    periphReq,
   input  wire logic [EVT_W-1:0]                           evtCh,
   output logic                                            busReq,
   input  wire logic                                       busGnt,
   output logic                                            accValid,
   output mte_pkg::mte_acc_t                               acc,
   input  wire logic                                       accAck,
   input  wire logic [7:0]                                 accRdata,
   output logic                                            irq
);
   import mte_pkg::*;

   mte_cfg_t                cfg_ff      [MTE_CH];
   logic [23:0]             startSrc_ff [MTE_CH];
   logic [23:0]             startDst_ff [MTE_CH];
   logic [23:0]             curSrc_ff   [MTE_CH];
   logic [23:0]             curDst_ff   [MTE_CH];
   logic [15:0]             blkLen_ff   [MTE_CH];
   logic [16:0]             blkCnt_ff   [MTE_CH];
   logic [7:0]              repCfg_ff   [MTE_CH];
   logic [7:0]              repLeft_ff  [MTE_CH];
   logic [MTE_CH-1:0]       pend_ff;
   logic [MTE_CH-1:0]       trigPrev_ff;
   logic [MTE_CH-1:0]       trigLvl;
   logic [MTE_CH-1:0]       trigHit;
   logic [MTE_CH-1:0]       chEn;
   logic [MTE_CH-1:0]       doneEv;
   logic [MTE_CH-1:0]       errEv;
   logic                    glbEn_ff;
   logic [7:0]              prio_ff;
   logic [7:0]              istat_ff;
   logic [7:0]              imask_ff;
   logic                    irq_ff;
   mte_state_t              state_ff;
   logic [MTE_CH_W-1:0]     act_ff;
   logic [3:0]              burstLeft_ff;
   logic [7:0]              data_ff;
   logic                    busReq_ff;
   logic                    accValid_ff;
   mte_acc_t                acc_ff;
   logic [31:0]             prdata_ff;
   logic                    pready_ff;
   logic                    pslverr_ff;
   logic                    arbValid;
   logic [MTE_CH_W-1:0]     arbIdx;
   logic                    setup;
   logic                    wrEn;
   logic [7:0]              chRel;
   logic                    chOk;
   logic [MTE_CH_W-1:0]     chNum;
   logic [31:0]             rdVal;
   logic                    rdOk;
   logic                    byteDone;
   logic                    lastByte;
   logic                    burstEnd;
   logic                    errAbort;
   logic                    nvWrite;

   assign prdata   = prdata_ff;
   assign pready   = pready_ff;
   assign pslverr  = pslverr_ff;
   assign busReq   = busReq_ff;
   assign accValid = accValid_ff;
   assign acc      = acc_ff;
   assign irq      = irq_ff;

   function automatic logic [23:0] stepAddr(input logic [23:0] a, input logic [1:0] m);
      if (m == MTE_STEP_INC) begin
         return a + 24'h000001;
      end else if (m == MTE_STEP_DEC) begin
         return a - 24'h000001;
      end
      return a;
   endfunction

   // a length of zero stands for a full 64K block
   function automatic logic [16:0] blkFull(input logic [15:0] l);
      return {(l == 16'h0000), l};
   endfunction

   // apb decode; channel windows are 0x20 apart starting at MTE_CH_BASE
   assign setup = psel && !penable;
   assign wrEn  = psel && penable && pwrite && pready_ff;
   assign chRel = paddr - MTE_CH_BASE;
   assign chOk  = (paddr >= MTE_CH_BASE) && !chRel[7];
   assign chNum = chRel[6:5];

   always_comb begin
      rdVal = 32'h0000_0000;
      rdOk  = 1'b1;
      if (paddr[1:0] != 2'b00) begin
         rdOk = 1'b0;
      end else if (chOk) begin
         unique case (chRel[4:0])
            MTE_CR_CFG:  rdVal = {19'h00000, cfg_ff[chNum]};
            MTE_CR_SRC:  rdVal = {8'h00, curSrc_ff[chNum]};
            MTE_CR_DST:  rdVal = {8'h00, curDst_ff[chNum]};
            MTE_CR_LEN:  rdVal = {16'h0000, blkLen_ff[chNum]};
            MTE_CR_REP:  rdVal = {24'h000000, repCfg_ff[chNum]};
            MTE_CR_LEFT: rdVal = {15'h0000, blkCnt_ff[chNum]};
            default:     rdOk  = 1'b0;
         endcase
      end else begin
         unique case (paddr)
            MTE_OFF_CTRL:  rdVal = {23'h000000, prio_ff, glbEn_ff};
            MTE_OFF_ISTAT: rdVal = {24'h000000, istat_ff};
            MTE_OFF_IMASK: rdVal = {24'h000000, imask_ff};
            MTE_OFF_STAT:  rdVal = {21'h000000, act_ff, (state_ff != MTE_ST_IDLE), pend_ff, chEn};
            default:       rdOk  = 1'b0;
         endcase
      end
   end

   // zero-wait slave: data and pready prepared in the setup cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= setup;
         prdata_ff  <= (setup && rdOk) ? rdVal : 32'h0000_0000;
         pslverr_ff <= setup && !rdOk;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         glbEn_ff <= 1'b0;
         prio_ff  <= MTE_PRIO_RST;
         imask_ff <= MTE_IMASK_RST;
      end else if (wrEn && !chOk) begin
         if (paddr == MTE_OFF_CTRL) begin
            glbEn_ff <= pwdata[MTE_CTRL_EN];
            prio_ff  <= pwdata[MTE_CTRL_PRIO +: 8];
         end
         if (paddr == MTE_OFF_IMASK) begin
            imask_ff <= pwdata[7:0];
         end
      end
   end

   // sticky flags: a new event beats a write-one clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         istat_ff <= 8'h00;
         irq_ff   <= 1'b0;
      end else begin
         if (wrEn && !chOk && paddr == MTE_OFF_ISTAT) begin
            istat_ff <= (istat_ff & ~pwdata[7:0]) | {errEv, doneEv};
         end else begin
            istat_ff <= istat_ff | {errEv, doneEv};
         end
         irq_ff <= |(istat_ff & imask_ff);
      end
   end

   // engine-side event pulses
   assign byteDone = (state_ff == MTE_ST_WRITE) && accValid_ff && accAck;
   assign lastByte = (blkCnt_ff[act_ff] == 17'h00001) && (repLeft_ff[act_ff] == 8'h00);
   assign burstEnd = byteDone && (lastByte || burstLeft_ff == 4'h1);
   // writes into the nonvolatile window are refused
   // the i/o region carries no restriction
   assign nvWrite  = (curDst_ff[act_ff] >= MTE_NV_FIRST) && (curDst_ff[act_ff] <= MTE_NV_LAST);
   assign errAbort = (state_ff == MTE_ST_READ) && !accValid_ff && busGnt && nvWrite;

   genvar gc;
   generate
      for (gc = 0; gc < MTE_CH; gc++) begin : g_ch
         assign chEn[gc]   = cfg_ff[gc].en;
         assign doneEv[gc] = byteDone && lastByte && (act_ff == MTE_CH_W'(gc));
         assign errEv[gc]  = errAbort && (act_ff == MTE_CH_W'(gc));

         // each channel has its own peripheral lines
         always_comb begin
            trigLvl[gc] = 1'b0;
            if (cfg_ff[gc].trigSel >= MTE_TRIG_PER0 && cfg_ff[gc].trigSel <= MTE_TRIG_PERN) begin
               trigLvl[gc] = periphReq[gc][2'(cfg_ff[gc].trigSel - MTE_TRIG_PER0)];
            end else if (cfg_ff[gc].trigSel >= MTE_TRIG_EVT0) begin
               trigLvl[gc] = evtCh[3'(cfg_ff[gc].trigSel - MTE_TRIG_EVT0)];
            end
         end

         // software request bit is only honoured with the enable in the same write
         assign trigHit[gc] = (wrEn && chOk && chNum == MTE_CH_W'(gc) && chRel[4:0] == MTE_CR_CFG
                               && pwdata[MTE_CFG_SWREQ] && pwdata[MTE_CTRL_EN])
                              || (cfg_ff[gc].en && trigLvl[gc] && !trigPrev_ff[gc]);

         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               trigPrev_ff[gc] <= 1'b0;
               pend_ff[gc]     <= 1'b0;
            end else begin
               trigPrev_ff[gc] <= trigLvl[gc];
               // a trigger in the clearing cycle stays pending
               pend_ff[gc] <= trigHit[gc]
                              || (pend_ff[gc] && !((burstEnd || errAbort)
                                                   && act_ff == MTE_CH_W'(gc)));
            end
         end
      end
   endgenerate

   mte_prio_arb u_arb (
      .req   (pend_ff & chEn & {MTE_CH{glbEn_ff}}),
      .order (prio_ff),
      .valid (arbValid),
      .idx   (arbIdx)
   );

   // per-channel configuration and progress; software writes land last
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int c = 0; c < MTE_CH; c++) begin
            cfg_ff[c]      <= '0;
            startSrc_ff[c] <= 24'h000000;
            startDst_ff[c] <= 24'h000000;
            curSrc_ff[c]   <= 24'h000000;
            curDst_ff[c]   <= 24'h000000;
            blkLen_ff[c]   <= 16'h0000;
            blkCnt_ff[c]   <= 17'h10000;
            repCfg_ff[c]   <= 8'h00;
            repLeft_ff[c]  <= 8'h00;
         end
      end else begin
         for (int c = 0; c < MTE_CH; c++) begin
            if (byteDone && act_ff == MTE_CH_W'(c)) begin
               curSrc_ff[c] <= stepAddr(curSrc_ff[c], cfg_ff[c].srcMode);
               curDst_ff[c] <= stepAddr(curDst_ff[c], cfg_ff[c].dstMode);
               if (blkCnt_ff[c] != 17'h00001) begin
                  blkCnt_ff[c] <= blkCnt_ff[c] - 17'h00001;
               end else if (repLeft_ff[c] != 8'h00) begin
                  blkCnt_ff[c]  <= blkFull(blkLen_ff[c]);
                  repLeft_ff[c] <= repLeft_ff[c] - 8'h01;
               end else begin
                  blkCnt_ff[c]  <= blkFull(blkLen_ff[c]);
                  repLeft_ff[c] <= repCfg_ff[c];
                  cfg_ff[c].en  <= 1'b0;
                  if (cfg_ff[c].reload) begin
                     curSrc_ff[c] <= startSrc_ff[c];
                     curDst_ff[c] <= startDst_ff[c];
                  end
               end
            end
            if (errEv[c]) begin
               cfg_ff[c].en <= 1'b0;
            end
            // partner completion hands the transfer over
            if (doneEv[c ^ 1] && cfg_ff[c ^ 1].link) begin
               cfg_ff[c].en <= 1'b1;
            end
            if (wrEn && chOk && chNum == MTE_CH_W'(c)) begin
               unique case (chRel[4:0])
                  MTE_CR_CFG: cfg_ff[c] <= mte_cfg_t'(pwdata[MTE_CFG_W-1:0]);
                  MTE_CR_SRC: begin
                     startSrc_ff[c] <= pwdata[23:0];
                     curSrc_ff[c]   <= pwdata[23:0];
                  end
                  MTE_CR_DST: begin
                     startDst_ff[c] <= pwdata[23:0];
                     curDst_ff[c]   <= pwdata[23:0];
                  end
                  MTE_CR_LEN: begin
                     blkLen_ff[c] <= pwdata[15:0];
                     blkCnt_ff[c] <= blkFull(pwdata[15:0]);
                  end
                  MTE_CR_REP: begin
                     repCfg_ff[c]  <= pwdata[7:0];
                     repLeft_ff[c] <= pwdata[7:0];
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   // byte mover: read the source, then write the destination, each under grant
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_ff     <= MTE_ST_IDLE;
         act_ff       <= '0;
         burstLeft_ff <= 4'h0;
         data_ff      <= 8'h00;
         busReq_ff    <= 1'b0;
         accValid_ff  <= 1'b0;
         acc_ff       <= '0;
      end else begin
         unique case (state_ff)
            MTE_ST_IDLE: begin
               if (arbValid) begin
                  act_ff       <= arbIdx;
                  burstLeft_ff <= 4'h1 << cfg_ff[arbIdx].burst;
                  busReq_ff    <= 1'b1;
                  state_ff     <= MTE_ST_READ;
               end
            end
            MTE_ST_READ: begin
               if (!accValid_ff && busGnt) begin
                  if (nvWrite) begin
                     // refused before any bus traffic so nothing half-moves
                     busReq_ff <= 1'b0;
                     state_ff  <= MTE_ST_IDLE;
                  end else begin
                     accValid_ff <= 1'b1;
                     acc_ff      <= '{addr: curSrc_ff[act_ff], wr: 1'b0, wdata: 8'h00};
                  end
               end else if (accValid_ff && accAck) begin
                  accValid_ff <= 1'b0;
                  data_ff     <= accRdata;
                  state_ff    <= MTE_ST_WRITE;
               end
            end
            MTE_ST_WRITE: begin
               if (!accValid_ff && busGnt) begin
                  accValid_ff <= 1'b1;
                  acc_ff      <= '{addr: curDst_ff[act_ff], wr: 1'b1, wdata: data_ff};
               end else if (accValid_ff && accAck) begin
                  accValid_ff <= 1'b0;
                  if (burstEnd) begin
                     busReq_ff <= 1'b0;
                     state_ff  <= MTE_ST_IDLE;
                  end else begin
                     burstLeft_ff <= burstLeft_ff - 4'h1;
                     state_ff     <= MTE_ST_READ;
                  end
               end
            end
            default: begin
               state_ff    <= MTE_ST_IDLE;
               busReq_ff   <= 1'b0;
               accValid_ff <= 1'b0;
            end
         endcase
      end
   end

endmodule

// file: hdl/mte_prio_arb.sv
/*
 fixed-order arbiter: picks the pending channel named in the earliest
 slot of a programmable order list.
 assumes the order list is a permutation of channel numbers.
*/
module mte_prio_arb (
   input  wire logic [mte_pkg::MTE_CH-1:0]                 req,
   input  wire logic [mte_pkg::MTE_CH*mte_pkg::MTE_CH_W-1:0] order,
   output logic                                            valid,
   output logic [mte_pkg::MTE_CH_W-1:0]                    idx
);
   import mte_pkg::*;

   // walk from the highest slot downward so the lowest slot wins last
   always_comb begin
      valid = 1'b0;
      idx   = '0;
      for (int s = MTE_CH - 1; s >= 0; s--) begin
         if (req[order[s*MTE_CH_W +: MTE_CH_W]]) begin
            valid = 1'b1;
            idx   = order[s*MTE_CH_W +: MTE_CH_W];
         end
      end
   end

endmodule

// file: testbench/mte_bus_model.sv
/* shared data bus partner: grants the bus and answers byte accesses.
 assumes one access at a time; slow thins grants and adds wait cycles. */
module mte_bus_model (
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic              slow,
   input  wire logic              busReq,
   output logic                   busGnt,
   input  wire logic              accValid,
   input  wire mte_pkg::mte_acc_t acc,
   output logic                   accAck,
   output logic [7:0]             accRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import mte_pkg::*;
   logic [7:0] mem [logic [23:0]];
   int         waitN;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         busGnt <= 1'b0;
         accAck <= 1'b0;
         accRdata <= 8'h00;
         waitN = 0;
      end else begin
         // core takes the bus back every other cycle when slow
         busGnt <= busReq && !(slow && busGnt);
         accAck <= 1'b0;
         // released data never keeps the last value
         accRdata <= ~accRdata;
         if (accValid && !accAck) begin
            if (slow && waitN < 2) begin
               waitN = waitN + 1;
            end else begin
               waitN = 0;
               accAck <= 1'b1;
               if (acc.wr) begin
                  mem[acc.addr] = acc.wdata;
               end else begin
                  accRdata <= acc.addr[7:0] ^ acc.addr[15:8] ^ 8'h5a;
               end
            end
         end
      end
   end
endmodule

// file: testbench/mte_engine_asserts.sv
/* checker on the transfer engine ports: bus access and apb timing.
 assumes it is bound onto mte_engine; one clock domain. */
module mte_engine_asserts (
   input wire logic              core_clk,
   input wire logic              sys_rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pready,
   input wire logic              busReq,
   input wire logic              busGnt,
   input wire logic              accValid,
   input wire mte_pkg::mte_acc_t acc,
   input wire logic              accAck,
   input wire logic [7:0]        accRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import mte_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [7:0] rdHold_ff;
   // last byte read, which the following write must carry
   always_ff @(posedge core_clk) begin
      if (accValid && accAck && !acc.wr) begin
         rdHold_ff <= accRdata;
      end
   end
   sequence rdDone;
      accValid && accAck && !acc.wr;
   endsequence
   sequence wrStart;
      !accValid ##[1:40] (accValid && acc.wr);
   endsequence
   AST_ACC_HOLD: assert property (accValid && !accAck |=> accValid && $stable(acc))
      else $error("access changed before ack");
   AST_ACC_GNT: assert property ($rose(accValid) |-> $past(busGnt))
      else $error("access started without grant");
   AST_ACC_IN_REQ: assert property (accValid |-> busReq)
      else $error("access outside bus request");
   AST_ACC_END: assert property (accValid && accAck |=> !accValid)
      else $error("access held after ack");
   AST_NV_NO_WR: assert property (accValid && acc.wr |->
      !(acc.addr >= MTE_NV_FIRST && acc.addr <= MTE_NV_LAST))
      else $error("write into nonvolatile window");
   AST_WDATA: assert property (accValid && acc.wr |-> acc.wdata == rdHold_ff)
      else $error("written byte differs from read byte");
   AST_RD_THEN_WR: assert property (rdDone |=> wrStart)
      else $error("no write after read");
   AST_APB_READY: assert property (psel && !penable |=> pready)
      else $error("register access not answered");
endmodule
bind mte_engine mte_engine_asserts mte_engine_asserts_i (.core_clk(core_clk),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready), .busReq(busReq),
   .busGnt(busGnt), .accValid(accValid), .acc(acc), .accAck(accAck), .accRdata(accRdata));

// file: testbench/testbench.sv
/* self-checking bench: apb tasks, one transfer per channel, refused write.
 assumes the checker binds itself and the bus model answers every access. */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import mte_pkg::*;
   logic              core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr, evtCh, accRdata;
   logic [31:0]       pwdata, prdata, v;
   logic [3:0][3:0]   periphReq;
   logic              busReq, busGnt, accValid, accAck, irq, slow, slvErr;
   mte_acc_t          acc;
   int                errCount, nChecks;
   mte_engine mte_engine_i (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .periphReq, .evtCh, .busReq, .busGnt, .accValid, .acc,
      .accAck, .accRdata, .irq);
   mte_bus_model mte_bus_model_i (.core_clk, .sys_rst, .slow, .busReq, .busGnt,
      .accValid, .acc, .accAck, .accRdata);
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic completeRun();
      $display("checks %0d errors %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
      if (k >= 20) begin
         errCount++;
         completeRun();
      end
   endtask
   function automatic logic [7:0] chA(int c, logic [4:0] o);
      return MTE_CH_BASE + 8'(c * 32) + 8'(o);
   endfunction
   function automatic logic [23:0] step(logic [1:0] m);
      return m == MTE_STEP_INC ? 24'h1 : m == MTE_STEP_DEC ? 24'hffffff : 24'h0;
   endfunction
   task automatic pulse(int c, logic [31:0] cfg);
      logic [31:0] r;
      if (c == 1) periphReq[1][0] <= 1'b1;
      else if (c == 2) evtCh[2] <= 1'b1;
      else apb(1'b1, chA(c, MTE_CR_CFG), cfg | 32'h2000, r);
      @(posedge core_clk);
      periphReq[1][0] <= 1'b0;
      evtCh[2] <= 1'b0;
   endtask
   task automatic runCh(int c);
      logic [1:0]  sm, dm;
      logic [3:0]  ts;
      logic [23:0] s0, d0, sa, da;
      logic [31:0] cfg;
      mte_cfg_t    f;
      logic [7:0]  exp [logic [23:0]];
      int          n, k;
      sm = (c == 1) ? MTE_STEP_DEC : (c == 2) ? 2'b00 : MTE_STEP_INC;
      dm = (c == 2) ? MTE_STEP_DEC : (c == 3) ? 2'b11 : MTE_STEP_INC;
      ts = (c == 1) ? MTE_TRIG_PER0 : (c == 2) ? MTE_TRIG_EVT0 + 4'h2 : 4'h0;
      s0 = 24'h2040 + 24'(c * 256);
      d0 = 24'h3040 + 24'(c * 256);
      n = (c == 3) ? 16 : 8;
      f = '{ts, c == 0, ~c[0], dm, sm, 2'(c), 1'b1};
      cfg = {19'h0, f};
      sa = s0;
      da = d0;
      for (int i = 0; i < n; i++) begin
         exp[da] = sa[7:0] ^ sa[15:8] ^ 8'h5a;
         sa = sa + step(sm);
         da = da + step(dm);
      end
      slow <= c[0];
      apb(1'b1, chA(c, MTE_CR_SRC), 32'(s0), v);
      apb(1'b1, chA(c, MTE_CR_DST), 32'(d0), v);
      apb(1'b1, chA(c, MTE_CR_LEN), 32'h8, v);
      apb(1'b1, chA(c, MTE_CR_REP), 32'(c == 3), v);
      apb(1'b1, chA(c, MTE_CR_CFG), cfg, v);
      k = 0;
      do begin
         pulse(c, cfg);
         repeat (100) @(posedge core_clk);
         apb(1'b0, MTE_OFF_ISTAT, 32'h0, v);
         k++;
      end while (v[c] !== 1'b1 && k < 16);
      check("done flag", 32'(v[c]), 32'h1);
      check("irq", 32'(irq), 32'(c == 0));
      foreach (exp[a]) check("dest byte", 32'(mte_bus_model_i.mem[a]), 32'(exp[a]));
      apb(1'b0, chA(c, MTE_CR_SRC), 32'h0, v);
      check("src after", v, 32'(c[0] ? sa : s0));
      if (c == 0) begin
         apb(1'b0, MTE_OFF_STAT, 32'h0, v);
         check("link enable", 32'(v[1:0]), 32'h2);
      end
      apb(1'b1, MTE_OFF_ISTAT, 32'hff, v);
      @(posedge core_clk);
      check("irq cleared", 32'(irq), 32'h0);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      repeat (90000) @(posedge core_clk);
      errCount++;
      completeRun();
   end
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata, evtCh, slow} = '0;
      periphReq = '0;
      sys_rst = 1'b1;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, MTE_OFF_CTRL, 32'h0, v);
      check("ctrl reset", v, {23'h0, MTE_PRIO_RST, 1'b0});
      apb(1'b0, chA(3, MTE_CR_LEFT), 32'h0, v);
      check("left reset", v, 32'h10000);
      apb(1'b0, 8'h1c, 32'h0, v);
      check("unmapped error", 32'(slvErr), 32'h1);
      apb(1'b1, MTE_OFF_CTRL, {23'h0, MTE_PRIO_RST, 1'b1}, v);
      apb(1'b1, MTE_OFF_IMASK, 32'h1, v);
      for (int c = 0; c < MTE_CH; c++) runCh(c);
      // destination in the nonvolatile window must be refused
      apb(1'b1, chA(0, MTE_CR_DST), 32'(MTE_NV_FIRST), v);
      apb(1'b1, chA(0, MTE_CR_CFG), 32'h2001, v);
      repeat (20) @(posedge core_clk);
      apb(1'b0, MTE_OFF_ISTAT, 32'h0, v);
      check("refused write", 32'(v[4]), 32'h1);
      completeRun();
   end
endmodule
